/* verilog/pllcf_pkg.sv */
/*
  constants and carrier types for the loop-control field decoder:
  register addresses, field positions, reset values and select codes.
  assumes the 32-bit serial word carries its register address in the low
  four bits and is shifted in most significant bit first.
*/
package pllcf_pkg;
  // serial word and addresses
  localparam int WORD_W = 32;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'he; // pll_control_word
  localparam logic [ADDR_W-1:0] ADDR_FB = 4'hf; // feedback_divider_word
  // field positions in pll_control_word
  localparam int GATE_BIT = 27;
  localparam int SHDN_BIT = 26;
  localparam int FLOAT_BIT = 25;
  localparam int POL_BIT = 24;
  localparam int SEL_LSB = 20;
  localparam int SEL_W = 4;
  localparam int RDIV_LSB = 8;
  localparam int RDIV_W = 12;
  // field positions in feedback_divider_word
  localparam int FDIV_LSB = 8;
  localparam int FDIV_W = 18;
  localparam int GAIN_LSB = 30;
  localparam int GAIN_W = 2;
  // reset values
  localparam logic GATE_RST = 1'h1;
  localparam logic SHDN_RST = 1'h0;
  localparam logic FLOAT_RST = 1'h0;
  localparam logic POL_RST = 1'h0;
  localparam logic [SEL_W-1:0] SEL_RST = 4'h0;
  localparam logic [RDIV_W-1:0] RDIV_RST = 12'h00a; // 10
  localparam logic [FDIV_W-1:0] FDIV_RST = 18'h002f8; // 760
  localparam logic [GAIN_W-1:0] GAIN_RST = 2'h0;
  // lock status pin select codes
  localparam logic [SEL_W-1:0] SEL_HIZ = 4'h0;
  localparam logic [SEL_W-1:0] SEL_HIGH = 4'h1;
  localparam logic [SEL_W-1:0] SEL_LOW = 4'h2;
  localparam logic [SEL_W-1:0] SEL_LOCK = 4'h3;
  localparam logic [SEL_W-1:0] SEL_NLOCK = 4'h4;
  localparam logic [SEL_W-1:0] SEL_FBHALF = 4'h9;
  localparam logic [SEL_W-1:0] SEL_REFHALF = 4'hb;
  // pump current multipliers
  localparam int SCALE_W = 6;
  localparam logic [SCALE_W-1:0] SCALE_X1 = 6'h01;
  localparam logic [SCALE_W-1:0] SCALE_X4 = 6'h04;
  localparam logic [SCALE_W-1:0] SCALE_X16 = 6'h10;
  localparam logic [SCALE_W-1:0] SCALE_X32 = 6'h20;

  // loaded configuration fields
  typedef struct packed {
    logic global_output_gate;
    logic whole_device_shutdown;
    logic pump_float;
    logic pump_polarity;
    logic [SEL_W-1:0] lock_sel;
    logic [RDIV_W-1:0] ref_div;
    logic [FDIV_W-1:0] fb_div;
    logic [GAIN_W-1:0] pump_gain_select;
  } pllcf_cfg_t;

  // two-signal view of the lock status pin
  typedef struct packed {
    logic out;
    logic oe;
  } pllcf_pin_t;
endpackage

/* verilog/pllcf_top.sv */
/*
  loop-control field decoder: serial configuration port, field registers,
  lock status pin mux, output gating and the two loop dividers.
  assumes all inputs are synchronous to MCLK_I; divider inputs arrive as
  one-cycle tick strobes, one per oscillator or reference edge.
*/
`timescale 1ns/1ns
// How it works
// - lock pin select 4 bits: 0 hi-z default, 1 high, 2 low
// - select 3 drives the lock indication, high while locked
// - select 4 drives the inverted lock indication, low while locked
// - select 9 drives feedback divider output halved, square wave
// - select 11 drives reference divider output halved, square wave
// - shutdown bit 1 floats the lock pin and pump, turns clock outputs off, stalls both dividers; 0 default normal
// - global gate overrides every individual output enable
// - global gate 0 turns all clock outputs off; 1 default
// - pump float bit 1 puts the charge pump in hi-z
// - pump polarity 0 negative default, 1 positive
// - feedback divider 18 bits, 1 to 262143, zero invalid, default 760
// - feedback divider output drives the phase detector
// - pump gain 2 bits: 1x default, 4x, 16x, 32x
// - reference divider 12 bits, 1 to 4095, zero invalid, default 10
// - gate 0 or enable pin low disables all clock outputs
module pllcf_top #(
  parameter int N_OUT = 8
) (
  input wire logic MCLK_I,
  input wire logic NRST_I,
  input wire logic CE_I,
  input wire logic SER_CLK_I,
  input wire logic SER_DATA_I,
  input wire logic SER_LATCH_I,
  input wire logic LOCK_I,
  input wire logic FB_TICK_I,
  input wire logic REF_TICK_I,
  input wire logic OUTPUT_ENABLE_PIN_I,
  input wire logic [N_OUT-1:0] PER_OUTPUT_ENABLE_I,
  output logic LOCK_STATUS_PIN_O,
  output logic LOCK_STATUS_PIN_OE_O,
  output pllcf_pkg::pllcf_cfg_t CFG_O,
  output logic [N_OUT-1:0] CLK_EN_O,
  output logic PUMP_FLOAT_O,
  output logic PUMP_POLARITY_O,
  output logic [pllcf_pkg::SCALE_W-1:0] PUMP_SCALE_O,
  output logic FB_PULSE_O,
  output logic REF_PULSE_O,
  output logic DIV_FAULT_O
);
  import pllcf_pkg::*;

  // maps the gain code to its current multiplier
  function automatic logic [SCALE_W-1:0] gain_scale(
    input logic [GAIN_W-1:0] code
  );
    logic [SCALE_W-1:0] s;
    s = SCALE_X1;
    case (code)
      2'h1: s = SCALE_X4;
      2'h2: s = SCALE_X16;
      2'h3: s = SCALE_X32;
      default: s = SCALE_X1;
    endcase
    return s;
  endfunction

  logic rst_meta_reg;
  logic rst_n;
  logic sclk_prev_reg, sclk_prev_next;
  logic latch_prev_reg, latch_prev_next;
  logic [WORD_W-1:0] shift_reg, shift_next;
  pllcf_cfg_t cfg_reg, cfg_next;
  pllcf_pin_t pin_reg, pin_next;
  logic [N_OUT-1:0] clk_en_reg, clk_en_next;
  logic float_reg, float_next;
  logic pol_reg, pol_next;
  logic [SCALE_W-1:0] scale_reg, scale_next;
  logic fault_reg, fault_next;
  logic [1:0] half_w;
  logic [1:0] pulse_w;
  logic [1:0] tick_w;
  logic [1:0][FDIV_W-1:0] div_w;

  // reset release through two flip-flops
  always_ff @(posedge MCLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      rst_meta_reg <= 1'h0;
      rst_n <= 1'h0;
    end
    else
    begin
      rst_meta_reg <= 1'h1;
      rst_n <= rst_meta_reg;
    end
  end

  // serial shifter and field load on the latch rising edge
  always_comb
  begin
    sclk_prev_next = SER_CLK_I;
    latch_prev_next = SER_LATCH_I;
    shift_next = shift_reg;
    cfg_next = cfg_reg;
    if (SER_CLK_I && !sclk_prev_reg)
      shift_next = {shift_reg[WORD_W-2:0], SER_DATA_I};
    if (SER_LATCH_I && !latch_prev_reg)
    begin
      if (shift_reg[ADDR_W-1:0] == ADDR_CTRL)
      begin
        cfg_next.global_output_gate = shift_reg[GATE_BIT];
        cfg_next.whole_device_shutdown = shift_reg[SHDN_BIT];
        cfg_next.pump_float = shift_reg[FLOAT_BIT];
        cfg_next.pump_polarity = shift_reg[POL_BIT];
        cfg_next.lock_sel = shift_reg[SEL_LSB +: SEL_W];
        cfg_next.ref_div = shift_reg[RDIV_LSB +: RDIV_W];
      end
      else if (shift_reg[ADDR_W-1:0] == ADDR_FB)
      begin
        cfg_next.fb_div = shift_reg[FDIV_LSB +: FDIV_W];
        cfg_next.pump_gain_select = shift_reg[GAIN_LSB +: GAIN_W];
      end
    end
  end

  always_ff @(posedge MCLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclk_prev_reg <= 1'h0;
      latch_prev_reg <= 1'h0;
      shift_reg <= '0;
      cfg_reg <= '{GATE_RST, SHDN_RST, FLOAT_RST, POL_RST, SEL_RST,
        RDIV_RST, FDIV_RST, GAIN_RST};
    end
    else if (CE_I)
    begin
      sclk_prev_reg <= sclk_prev_next;
      latch_prev_reg <= latch_prev_next;
      shift_reg <= shift_next;
      cfg_reg <= cfg_next;
    end
  end

  // feedback (0) and reference (1) dividers; zero value stalls the divider
  assign tick_w = {REF_TICK_I, FB_TICK_I};
  assign div_w[0] = cfg_reg.fb_div;
  assign div_w[1] = {{(FDIV_W-RDIV_W){1'h0}}, cfg_reg.ref_div};
  generate
    for (genvar d = 0; d < 2; d++)
    begin : g_div
      logic [FDIV_W-1:0] cnt_reg, cnt_next;
      logic half_reg, half_next;
      logic pulse_reg, pulse_next;
      // count ticks; wrap at value-1 with a pulse and a half-rate toggle
      always_comb
      begin
        cnt_next = cnt_reg;
        half_next = half_reg;
        pulse_next = 1'h0;
        if (!cfg_reg.whole_device_shutdown && div_w[d] != '0 && tick_w[d])
        begin
          if (cnt_reg >= div_w[d] - 18'h1)
          begin
            cnt_next = '0;
            pulse_next = 1'h1;
            half_next = ~half_reg;
          end
          else
            cnt_next = cnt_reg + 18'h1;
        end
      end
      always_ff @(posedge MCLK_I or negedge rst_n)
      begin
        if (!rst_n)
        begin
          cnt_reg <= '0;
          half_reg <= 1'h0;
          pulse_reg <= 1'h0;
        end
        else if (CE_I)
        begin
          cnt_reg <= cnt_next;
          half_reg <= half_next;
          pulse_reg <= pulse_next;
        end
      end
      assign half_w[d] = half_reg;
      assign pulse_w[d] = pulse_reg;
    end
  endgenerate

  // lock pin mux, output gating and pump controls
  always_comb
  begin
    pin_next = '{out: 1'h0, oe: 1'h1};
    case (cfg_reg.lock_sel)
      SEL_HIZ: pin_next.oe = 1'h0;
      SEL_HIGH: pin_next.out = 1'h1;
      SEL_LOW: pin_next.out = 1'h0;
      SEL_LOCK: pin_next.out = LOCK_I;
      SEL_NLOCK: pin_next.out = ~LOCK_I;
      SEL_FBHALF: pin_next.out = half_w[0];
      SEL_REFHALF: pin_next.out = half_w[1];
      default: pin_next.oe = 1'h0; // unsupported codes float
    endcase
    if (cfg_reg.whole_device_shutdown)
      pin_next = '{out: 1'h0, oe: 1'h0};
    clk_en_next = PER_OUTPUT_ENABLE_I;
    if (!cfg_reg.global_output_gate || !OUTPUT_ENABLE_PIN_I ||
        cfg_reg.whole_device_shutdown)
      clk_en_next = '0;
    float_next = cfg_reg.pump_float || cfg_reg.whole_device_shutdown;
    pol_next = cfg_reg.pump_polarity;
    scale_next = gain_scale(cfg_reg.pump_gain_select);
    fault_next = (cfg_reg.fb_div == '0) || (cfg_reg.ref_div == '0);
  end

  always_ff @(posedge MCLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_reg <= '{out: 1'h0, oe: 1'h0};
      clk_en_reg <= '0;
      float_reg <= FLOAT_RST;
      pol_reg <= POL_RST;
      scale_reg <= SCALE_X1;
      fault_reg <= 1'h0;
    end
    else if (CE_I)
    begin
      pin_reg <= pin_next;
      clk_en_reg <= clk_en_next;
      float_reg <= float_next;
      pol_reg <= pol_next;
      scale_reg <= scale_next;
      fault_reg <= fault_next;
    end
  end

  // outputs straight from flip-flops
  assign LOCK_STATUS_PIN_O = pin_reg.out;
  assign LOCK_STATUS_PIN_OE_O = pin_reg.oe;
  assign CFG_O = cfg_reg;
  assign CLK_EN_O = clk_en_reg;
  assign PUMP_FLOAT_O = float_reg;
  assign PUMP_POLARITY_O = pol_reg;
  assign PUMP_SCALE_O = scale_reg;
  assign FB_PULSE_O = pulse_w[0]; // phase detector feedback
  assign REF_PULSE_O = pulse_w[1];
  assign DIV_FAULT_O = fault_reg;

  // checks on the decoded behaviour
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!rst_n);

  hiz_select_a: assert property (CE_I && cfg_reg.lock_sel == SEL_HIZ
    |=> !LOCK_STATUS_PIN_OE_O) else $error("pin not floating");
  high_select_a: assert property (CE_I && cfg_reg.lock_sel == SEL_HIGH &&
    !cfg_reg.whole_device_shutdown |=> LOCK_STATUS_PIN_OE_O &&
    LOCK_STATUS_PIN_O) else $error("pin not high");
  lock_high_a: assert property (CE_I && cfg_reg.lock_sel == SEL_LOCK &&
    !cfg_reg.whole_device_shutdown |=> LOCK_STATUS_PIN_O == $past(LOCK_I))
    else $error("lock not followed");
  lock_low_a: assert property (CE_I && cfg_reg.lock_sel == SEL_NLOCK &&
    !cfg_reg.whole_device_shutdown |=> LOCK_STATUS_PIN_O != $past(LOCK_I))
    else $error("lock not inverted");
  fb_half_a: assert property (CE_I && cfg_reg.lock_sel == SEL_FBHALF &&
    !cfg_reg.whole_device_shutdown |=> LOCK_STATUS_PIN_O == $past(half_w[0]))
    else $error("feedback half wrong");
  ref_half_a: assert property (CE_I && cfg_reg.lock_sel == SEL_REFHALF &&
    !cfg_reg.whole_device_shutdown |=> LOCK_STATUS_PIN_O == $past(half_w[1]))
    else $error("reference half wrong");
  shutdown_all_a: assert property (CE_I && cfg_reg.whole_device_shutdown
    |=> !LOCK_STATUS_PIN_OE_O && CLK_EN_O == '0 && PUMP_FLOAT_O &&
    !FB_PULSE_O) else $error("shutdown leaked");
  gate_off_a: assert property (CE_I && !cfg_reg.global_output_gate
    |=> CLK_EN_O == '0) else $error("gate ignored");
  enable_pass_a: assert property (CE_I && cfg_reg.global_output_gate &&
    OUTPUT_ENABLE_PIN_I && !cfg_reg.whole_device_shutdown
    |=> CLK_EN_O == $past(PER_OUTPUT_ENABLE_I))
    else $error("enable lost");
  pin_off_a: assert property (CE_I && !OUTPUT_ENABLE_PIN_I
    |=> CLK_EN_O == '0) else $error("enable pin ignored");
  pump_float_a: assert property (CE_I && cfg_reg.pump_float
    |=> PUMP_FLOAT_O) else $error("pump not floating");
  pump_pol_a: assert property (CE_I |=> PUMP_POLARITY_O ==
    $past(cfg_reg.pump_polarity)) else $error("polarity wrong");
  gain_top_a: assert property (CE_I && cfg_reg.pump_gain_select == 2'h3
    |=> PUMP_SCALE_O == SCALE_X32) else $error("gain wrong");
  zero_div_a: assert property (cfg_reg.fb_div == '0 && $stable(cfg_reg)
    |=> !FB_PULSE_O) else $error("zero divider ran");
  div_one_a: assert property (CE_I && cfg_reg.fb_div == 18'h1 && FB_TICK_I
    && !cfg_reg.whole_device_shutdown |=> FB_PULSE_O)
    else $error("divide by one missed");

  lock_drive_c: cover property (cfg_reg.lock_sel == SEL_LOCK ##1
    LOCK_STATUS_PIN_OE_O && LOCK_STATUS_PIN_O);
  fb_pulse_c: cover property (FB_PULSE_O ##1 !FB_PULSE_O [*2] ##1
    FB_PULSE_O);
  shutdown_c: cover property ($rose(cfg_reg.whole_device_shutdown));
  outputs_on_c: cover property (CLK_EN_O != '0);
endmodule

/* tb/pllcf_host.sv */
/*
  host controller model: shifts one 32-bit word out msb first, then
  pulses the latch. assumes go_i is raised for one cycle while idle.
*/
`timescale 1ns/1ns
module pllcf_host (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [31:0] word_i,
  output logic sclk_o,
  output logic sdata_o,
  output logic latch_o,
  output logic busy_o
);
  // idle levels
  initial
  begin
    sclk_o = 1'b0;
    sdata_o = 1'b0;
    latch_o = 1'b0;
    busy_o = 1'b0;
  end

  // every serial level lasts a full cycle, changed on falling edges
  always @(posedge clk_i)
  begin
    if (go_i && !busy_o)
    begin
      busy_o = 1'b1;
      for (int i = 31; i >= 0; i--)
      begin
        @(negedge clk_i);
        sclk_o = 1'b0;
        sdata_o = word_i[i];
        @(negedge clk_i);
        sclk_o = 1'b1;
      end
      @(negedge clk_i);
      sclk_o = 1'b0;
      sdata_o = ~sdata_o; // data line inverted so the last bit is not left standing
      @(negedge clk_i);
      latch_o = 1'b1;
      @(negedge clk_i);
      latch_o = 1'b0;
      busy_o = 1'b0;
    end
  end
endmodule

/* tb/pllcf_top_test.sv */
/*
  self-checking bench: host model writes words, the driver queues the
  expected state, a monitor compares. assumes default N_OUT of 8.
*/
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); error_cnt++; end end
module pllcf_top_test;
  import pllcf_pkg::*;
  typedef struct packed {
    pllcf_cfg_t cfg;
    logic [7:0] en;
    logic [1:0] pin;
    logic [1:0] pump;
    logic [SCALE_W-1:0] scale;
    logic fault;
    logic [7:0] fbn;
    logic [7:0] refn;
    logic [7:0] togn;
  } pllcf_snap_t;
  logic clk, nrst, lock, fbt, reft, oep, go, sclk, sdata, slatch, busy;
  logic win, ce, chk, prev, pin_o, pin_oe, flt_o, pol_o;
  logic fbp, refp, fault_o;
  logic [7:0] per, en_o, fbn, refn, togn, e_fb, e_ref, e_tog;
  logic [31:0] word;
  logic [SCALE_W-1:0] scl_o;
  logic [SCALE_W-1:0] sc [4];
  pllcf_cfg_t m, cfg_o;
  pllcf_snap_t q[$];
  pllcf_snap_t e, a;
  int error_cnt, checks_done;

  pllcf_top pllcf_top_i (.MCLK_I(clk), .NRST_I(nrst), .CE_I(ce),
    .SER_CLK_I(sclk), .SER_DATA_I(sdata), .SER_LATCH_I(slatch),
    .LOCK_I(lock), .FB_TICK_I(fbt), .REF_TICK_I(reft),
    .OUTPUT_ENABLE_PIN_I(oep), .PER_OUTPUT_ENABLE_I(per),
    .LOCK_STATUS_PIN_O(pin_o), .LOCK_STATUS_PIN_OE_O(pin_oe), .CFG_O(cfg_o),
    .CLK_EN_O(en_o), .PUMP_FLOAT_O(flt_o), .PUMP_POLARITY_O(pol_o),
    .PUMP_SCALE_O(scl_o), .FB_PULSE_O(fbp), .REF_PULSE_O(refp),
    .DIV_FAULT_O(fault_o));
  pllcf_host pllcf_host_i (.clk_i(clk), .go_i(go), .word_i(word),
    .sclk_o(sclk), .sdata_o(sdata), .latch_o(slatch), .busy_o(busy));

  // clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // monitor: counts held at zero outside a window, queued comparisons
  always @(posedge clk)
  begin
    prev <= pin_o;
    if (!win)
    begin
      fbn <= 8'h00;
      refn <= 8'h00;
      togn <= 8'h00;
    end
    else
    begin
      fbn <= fbn + {7'h00, fbp};
      refn <= refn + {7'h00, refp};
      togn <= togn + {7'h00, pin_o != prev};
    end
    if (chk && q.size() > 0)
    begin
      e = q.pop_front();
      a = {cfg_o, en_o, pin_o & pin_oe, pin_oe, flt_o, pol_o, scl_o, fault_o,
        fbn, refn, togn};
      `CHK(a.cfg, e.cfg)
      `CHK(a.pin, e.pin)
      `CHK(a.en, e.en)
      `CHK(a.pump, e.pump)
      `CHK(a.scale, e.scale)
      `CHK(a.fault, e.fault)
      `CHK(a.fbn, e.fbn)
      `CHK(a.refn, e.refn)
      `CHK(a.togn, e.togn)
    end
  end

  // verdict and end of run
  task automatic conclude();
    begin
      $display("errors %0d checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask

  // randomise the pins, then queue what the outputs must show
  task automatic check_state();
    begin
      {lock, per} = 9'($urandom);
      oep = ($urandom % 4) != 0;
      repeat (2) @(negedge clk);
      e.cfg = m;
      e.pin = 2'b00;
      if (!m.whole_device_shutdown)
        case (m.lock_sel)
          SEL_HIGH: e.pin = 2'b11;
          SEL_LOW: e.pin = 2'b01;
          SEL_LOCK: e.pin = {lock, 1'b1};
          SEL_NLOCK: e.pin = {~lock, 1'b1};
          SEL_FBHALF, SEL_REFHALF: e.pin = 2'b01; // even toggle count
          default: e.pin = 2'b00;
        endcase
      e.en = (m.global_output_gate && oep && !m.whole_device_shutdown) ?
        per : 8'h00;
      e.pump = {m.pump_float | m.whole_device_shutdown, m.pump_polarity};
      e.scale = sc[m.pump_gain_select];
      e.fault = (m.fb_div == '0) || (m.ref_div == '0);
      {e.fbn, e.refn, e.togn} = {e_fb, e_ref, e_tog};
      q.push_back(e);
      chk = 1'b1;
      @(negedge clk);
      chk = 1'b0;
    end
  endtask

  // one serial word through the host model, bounded wait
  task automatic wr(input logic [31:0] w);
    int k;
    begin
      word = w;
      go = 1'b1;
      @(negedge clk);
      go = 1'b0;
      k = 0;
      while (busy && k < 200)
      begin
        @(posedge clk);
        k++;
      end
      if (k >= 200)
      begin
        error_cnt++;
        conclude();
      end
      @(negedge clk);
    end
  endtask

  task automatic wr_ctrl(input logic g, input logic s, input logic f,
    input logic p, input logic [3:0] sel, input logic [11:0] r);
    begin
      {m.global_output_gate, m.whole_device_shutdown} = {g, s};
      {m.pump_float, m.pump_polarity, m.lock_sel, m.ref_div} = {f, p, sel, r};
      wr({4'h0, g, s, f, p, sel, r, 4'h0, ADDR_CTRL});
    end
  endtask

  task automatic wr_fb(input logic [1:0] g, input logic [17:0] n);
    begin
      m.pump_gain_select = g;
      m.fb_div = n;
      wr({g, 4'h0, n, 4'h0, ADDR_FB});
    end
  endtask

  // ticks for n cycles inside a counting window, then a check
  task automatic tick_win(input logic f, input logic r, input int n);
    begin
      win = 1'b1;
      fbt = f;
      reft = r;
      repeat (n) @(negedge clk);
      fbt = 1'b0;
      reft = 1'b0;
      repeat (3) @(negedge clk);
      check_state();
      win = 1'b0;
    end
  endtask

  // watchdog
  initial
  begin
    #400000;
    error_cnt++;
    conclude();
  end

  // main sequence; supported select codes plus the unsupported code 6 are written
  initial
  begin
    logic [3:0] st [4];
    void'($urandom(32'hd30dda04));
    {nrst, lock, fbt, reft, oep, go, win, chk, per, word} = '0;
    ce = 1'b1;
    {error_cnt, checks_done, e_fb, e_ref, e_tog} = '0;
    sc = '{SCALE_X1, SCALE_X4, SCALE_X16, SCALE_X32};
    st = '{SEL_HIGH, SEL_LOW, SEL_LOCK, SEL_NLOCK};
    m = {GATE_RST, SHDN_RST, FLOAT_RST, POL_RST, SEL_RST, RDIV_RST,
      FDIV_RST, GAIN_RST};
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    check_state();
    for (int i = 0; i < 4; i++)
    begin
      wr_fb(i[1:0], 18'($urandom_range(262143, 1)));
      wr_ctrl(1, 0, i[0], i[1], st[i], 12'($urandom_range(4095, 1)));
      repeat (2) check_state();
    end
    wr_ctrl(0, 0, 0, 0, SEL_LOCK, 12'hfff);
    repeat (2) check_state();
    wr_fb(3, 18'h3ffff);
    wr_ctrl(1, 0, 0, 0, SEL_HIZ, 12'h001);
    check_state();
    wr(32'hffff_fff7); // unmapped address leaves every field alone
    check_state();
    wr_ctrl(1, 0, 0, 0, 4'h6, 12'h123); // analog code floats the pin
    check_state();
    wr_fb(0, 18'h00003);
    wr_ctrl(1, 0, 0, 0, SEL_FBHALF, 12'h005);
    {e_fb, e_ref, e_tog} = {8'h0a, 8'h00, 8'h0a};
    tick_win(1, 0, 30);
    wr_ctrl(1, 0, 0, 0, SEL_REFHALF, 12'h005);
    {e_fb, e_ref, e_tog} = {8'h00, 8'h06, 8'h06};
    tick_win(0, 1, 30);
    // clock enable low freezes dividers and pin: no pulse, no toggle
    @(negedge clk);
    {ce, win, fbt, reft} = 4'b0111;
    {e_fb, e_ref, e_tog} = '0;
    repeat (12) @(negedge clk);
    {ce, fbt, reft} = 3'b100;
    tick_win(0, 0, 1);
    wr_ctrl(1, 1, 0, 1, SEL_HIGH, 12'h005);
    {e_fb, e_ref, e_tog} = '0;
    tick_win(1, 1, 12);
    wr_ctrl(1, 0, 0, 0, SEL_HIGH, 12'h000);
    wr_fb(2, 18'h00000);
    tick_win(1, 1, 12); // zero dividers stall both counters
    // mid-run reset brings every field back to its default
    nrst = 1'b0;
    m = {GATE_RST, SHDN_RST, FLOAT_RST, POL_RST, SEL_RST, RDIV_RST,
      FDIV_RST, GAIN_RST};
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    check_state();
    conclude();
  end
endmodule
